// ===== logic/quad_line_if_host_port.v
// Host port of a quad T1/E1 line interface: strap decode, register access, wait states, alarm interrupt.
// Assumes host bus pins and straps are asynchronous; a tristate data pad is formed outside.
//
// What this block does
// - Chip mode strap high selects processor port, low selects direct pin control.
// - Multiplex strap high selects shared 8-bit bus, low separate 4-bit address.
// - Control style strap picks the control signal set; four modes result.
// - Shared bus mode offers an internal chip select matching a device id.
// - Cycles complete without wait states for hosts up to 16.384 MHz.
// - Faster hosts get cycles stretched by the wait/acknowledge output.
// - Alarm interrupt asserts high once per alarm activation when unmasked, in processor mode only.
// - Interrupt deasserts after the host reads the alarm status registers.
// - Per-line-interface masks decide which alarms drive the interrupt.
// - Clock rate strap 0 means 16x reference clock, 1 means line-rate clock.
`timescale 1ns/1ps
`include "host_port_defs.vh"
module quad_line_if_host_port #(
	parameter CHANNELS = `HP_CHANNELS,
	parameter [3:0] CHIP_ID = 4'h0,
	parameter WAIT_CYCLES = `HP_WAIT_CYCLES
) (
	input wire clock_i,
	input wire reset_i,
	input wire chip_mode_select_i,
	input wire bus_multiplex_select_i,
	input wire control_style_select_i,
	input wire ref_clock_rate_select_i,
	input wire ref_clock_standard_select_i,
	input wire fast_host_i,
	input wire [3:0] addr_i,
	input wire [7:0] ad_i,
	input wire ale_i,
	input wire cs_n_i,
	input wire strobe_a_n_i,
	input wire strobe_b_n_i,
	input wire [CHANNELS-1:0] alarm_i,
	output reg [7:0] ad_o,
	output reg ad_oe_n_o,
	output reg wait_acknowledge_out_o,
	output reg alarm_irq_o,
	output reg processor_mode_o,
	output reg ref_clock_16x_o,
	output reg ref_clock_e1_o,
	output reg [7:0] ctrl_o
);
	localparam ST_IDLE = 2'd0;
	localparam ST_WAIT = 2'd1;
	localparam ST_DONE = 2'd2;
	localparam [1:0] CFG_CAPTURE = `HP_STRAP_SETTLE;
	localparam [1:0] CFG_HOLD = 2'h3;
	wire [5:0] strap_s;
	wire [3:0] addr_s;
	wire [7:0] ad_s;
	wire [3:0] ctl_s;
	wire [CHANNELS-1:0] alarm_s;
	pin_sync #(.WIDTH(6)) u_strap (.clock_i(clock_i), .reset_i(reset_i),
		.async_i({fast_host_i, ref_clock_standard_select_i, ref_clock_rate_select_i,
			control_style_select_i, bus_multiplex_select_i, chip_mode_select_i}),
		.sync_o(strap_s));
	// Bus pins read as active right after reset, so requests wait for the captured mode
	pin_sync #(.WIDTH(16+CHANNELS)) u_bus (.clock_i(clock_i), .reset_i(reset_i),
		.async_i({alarm_i, strobe_b_n_i, strobe_a_n_i, cs_n_i, ale_i, ad_i, addr_i}),
		.sync_o({alarm_s, ctl_s, ad_s, addr_s}));
	reg [1:0] cfg_cnt_q;
	reg mux_q;
	reg style_q;
	reg fast_q;
	reg [3:0] latched_addr_q;
	reg id_match_q;
	reg [1:0] state_q;
	reg [7:0] wait_cnt_q;
	reg [CHANNELS-1:0] alarm_prev_q;
	reg [CHANNELS-1:0] alarm_sticky_q;
	reg [CHANNELS-1:0] mask_q;
	reg access_q;
	reg write_q;
	reg [3:0] acc_addr_q;
	// Per-channel vector placed in the low bits of a data byte
	function [7:0] widen_ch;
		input [CHANNELS-1:0] v;
		begin
			widen_ch = {{(8-CHANNELS){1'b0}}, v};
		end
	endfunction
	// Decode of the two control styles into read and write strobes
	function [1:0] decode_rw;
		input style;
		input sa_n;
		input sb_n;
		begin
			if (style)
				decode_rw = {~sa_n & ~sb_n, ~sa_n & sb_n};
			else
				decode_rw = {~sb_n, ~sa_n};
		end
	endfunction
	wire ale = ctl_s[0];
	wire cs_act = ~ctl_s[1];
	wire [1:0] rw = decode_rw(style_q, ctl_s[2], ctl_s[3]);
	wire selected = processor_mode_o & cs_act & (~mux_q | id_match_q);
	// A request needs chip select, a strobe and, on the shared bus, a matching chip id
	wire req = selected & (rw[0] | rw[1]);
	wire [3:0] eff_addr = mux_q ? latched_addr_q : addr_s;
	wire [CHANNELS-1:0] rise = alarm_s & ~alarm_prev_q;
	// Read of either alarm register clears the interrupt
	wire alarm_rd = (state_q == ST_DONE) & ~write_q &
		((acc_addr_q == `HP_ALARM_REG0) | (acc_addr_q == `HP_ALARM_REG1));
	// Strap capture: counted once after reset, then frozen
	always @(posedge clock_i) begin
		if (reset_i) begin
			cfg_cnt_q <= 2'd0;
			mux_q <= 1'b0;
			style_q <= 1'b0;
			fast_q <= 1'b0;
			processor_mode_o <= 1'b0;
			ref_clock_16x_o <= 1'b1;
			ref_clock_e1_o <= 1'b0;
		end else if (cfg_cnt_q != CFG_HOLD) begin
			cfg_cnt_q <= cfg_cnt_q + 2'd1;
			// Straps are taken only once the synchroniser holds their real level
			if (cfg_cnt_q == CFG_CAPTURE) begin
				processor_mode_o <= strap_s[0];
				mux_q <= strap_s[1];
				style_q <= strap_s[2];
				ref_clock_16x_o <= ~strap_s[3];
				ref_clock_e1_o <= strap_s[3] & strap_s[4];
				fast_q <= strap_s[5];
			end
		end
	end
	// Address phase of the shared bus also checks the chip id
	always @(posedge clock_i) begin
		if (reset_i) begin
			latched_addr_q <= 4'h0;
			id_match_q <= 1'b0;
		end else if (mux_q && ale) begin
			latched_addr_q <= ad_s[3:0];
			id_match_q <= (ad_s[7:4] == CHIP_ID);
		end
	end
	always @(posedge clock_i) begin
		if (reset_i) begin
			state_q <= ST_IDLE;
			wait_cnt_q <= 8'h00;
			wait_acknowledge_out_o <= 1'b0;
			write_q <= 1'b0;
			acc_addr_q <= 4'h0;
			ad_o <= 8'h00;
			ad_oe_n_o <= 1'b1;
			mask_q <= {CHANNELS{1'b0}};
			ctrl_o <= 8'h00;
		end else begin
			case (state_q)
				ST_IDLE: begin
					ad_oe_n_o <= 1'b1;
					wait_acknowledge_out_o <= 1'b0;
					if (req) begin
						write_q <= rw[1];
						acc_addr_q <= eff_addr;
						// Fast hosts see the answer only after this count runs out
						wait_cnt_q <= WAIT_CYCLES[7:0];
						if (fast_q)
							state_q <= ST_WAIT;
						else
							state_q <= ST_DONE;
					end
				end
				ST_WAIT: begin
					if (wait_cnt_q <= 8'h01)
						state_q <= ST_DONE;
					else
						wait_cnt_q <= wait_cnt_q - 8'h01;
				end
				ST_DONE: begin
					wait_acknowledge_out_o <= fast_q;
					if (!write_q) begin
						ad_oe_n_o <= 1'b0;
						case (acc_addr_q)
							`HP_ALARM_REG0: ad_o <= widen_ch(alarm_sticky_q);
							`HP_ALARM_REG1: ad_o <= widen_ch(alarm_s);
							`HP_MASK_REG0: ad_o <= widen_ch(mask_q);
							`HP_CTRL_REG0: ad_o <= ctrl_o;
							default: ad_o <= 8'h00;
						endcase
					// Writes stop once the strobe is seen gone; the data pins may already move
					end else if (req) begin
						case (acc_addr_q)
							`HP_MASK_REG0: mask_q <= ad_s[CHANNELS-1:0];
							`HP_CTRL_REG0: ctrl_o <= ad_s;
							default: ctrl_o <= ctrl_o;
						endcase
					end
					if (!req)
						state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
	always @(posedge clock_i) begin
		if (reset_i) begin
			alarm_prev_q <= {CHANNELS{1'b0}};
			alarm_sticky_q <= {CHANNELS{1'b0}};
			alarm_irq_o <= 1'b0;
			access_q <= 1'b0;
		end else begin
			// Sticky bits and the interrupt follow alarm rises, not levels
			alarm_prev_q <= alarm_s;
			access_q <= alarm_rd;
			// New activations win over the read-clear
			if (alarm_rd && !access_q)
				alarm_sticky_q <= rise;
			else
				alarm_sticky_q <= alarm_sticky_q | rise;
			if (|(rise & ~mask_q))
				alarm_irq_o <= processor_mode_o;
			else if (alarm_rd)
				alarm_irq_o <= 1'b0;
		end
	end
endmodule

// ===== logic/host_port_defs.vh
// Constants for the quad line interface host port.
// Assumes inclusion by bare name from design files under logic/.
`ifndef HOST_PORT_DEFS_VH
`define HOST_PORT_DEFS_VH
`define HP_ADDR_W 4
`define HP_DATA_W 8
`define HP_CHANNELS 4
`define HP_ALARM_REG0 4'h0
`define HP_ALARM_REG1 4'h1
`define HP_MASK_REG0 4'h2
`define HP_MASK_REG1 4'h3
`define HP_CTRL_REG0 4'h4
`define HP_MASK_RESET 8'h00
`define HP_STRAP_SETTLE 2'h2
`define HP_FAST_HOST_NS 61
`define HP_CLK_NS 10
`define HP_WAIT_CYCLES ((`HP_FAST_HOST_NS + `HP_CLK_NS - 1) / `HP_CLK_NS)
`endif

// ===== logic/pin_sync.v
// Two-stage synchroniser for a bundle of pin-level inputs.
// Assumes the inputs are asynchronous to clock_i.
`timescale 1ns/1ps
module pin_sync #(
	parameter WIDTH = 1
) (
	input wire clock_i,
	input wire reset_i,
	input wire [WIDTH-1:0] async_i,
	output reg [WIDTH-1:0] sync_o
);
	reg [WIDTH-1:0] meta_q;
	always @(posedge clock_i) begin
		if (reset_i) begin
			meta_q <= {WIDTH{1'b0}};
			sync_o <= {WIDTH{1'b0}};
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule

// ===== test/host_port_props.sv
// Pin-level checks for the host port.
// Assumes straps change only while reset is high.
`timescale 1ns/1ps
module host_port_props #(
	parameter CHANNELS = 4
) (
	input wire clock_i,
	input wire reset_i,
	input wire chip_mode_select_i,
	input wire ref_clock_rate_select_i,
	input wire fast_host_i,
	input wire cs_n_i,
	input wire [CHANNELS-1:0] alarm_i,
	input wire ad_oe_n_o,
	input wire wait_acknowledge_out_o,
	input wire alarm_irq_o,
	input wire processor_mode_o,
	input wire ref_clock_16x_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	a_direct_quiet: assert property (!processor_mode_o |-> ad_oe_n_o) else $error("direct drive");
	a_mode_strap: assert property ((!reset_i)[*5] |-> processor_mode_o == chip_mode_select_i) else $error("mode");
	a_rate_strap: assert property ((!reset_i)[*5] |-> ref_clock_16x_o != ref_clock_rate_select_i) else $error("rate");
	a_straps_held: assert property ((!reset_i)[*4] |=> $stable({processor_mode_o, ref_clock_16x_o})) else $error("moved");
	a_slow_noack: assert property (!fast_host_i |-> !wait_acknowledge_out_o) else $error("slow ack");
	a_ack_late: assert property ($fell(cs_n_i) && fast_host_i |-> !wait_acknowledge_out_o[*8]) else $error("early ack");
	a_ack_holds: assert property (wait_acknowledge_out_o && !cs_n_i |=> wait_acknowledge_out_o) else $error("ack drop");
	a_irq_cause: assert property ((alarm_i == '0)[*8] |=> !$rose(alarm_irq_o)) else $error("stray irq");
	cover property ($rose(alarm_irq_o));
	cover property ($rose(wait_acknowledge_out_o));
	cover property ($fell(ad_oe_n_o));
endmodule
bind quad_line_if_host_port host_port_props #(.CHANNELS(CHANNELS)) host_port_props_i (.clock_i, .reset_i,
	.chip_mode_select_i, .ref_clock_rate_select_i, .fast_host_i, .cs_n_i, .alarm_i, .ad_oe_n_o,
	.wait_acknowledge_out_o, .alarm_irq_o, .processor_mode_o, .ref_clock_16x_o);

// ===== test/host_model.sv
// Host processor model for the parallel port.
// Assumes straps stay static while an access runs.
`timescale 1ns/1ps
module host_model (
	input wire clock_i,
	input wire mux_i,
	input wire style_i,
	input wire fast_i,
	input wire oe_n_i,
	input wire ack_i,
	output logic [3:0] addr_o = 4'h0,
	output logic [7:0] ad_o = 8'h00,
	output logic ale_o = 1'b0,
	output logic cs_n_o = 1'b1,
	output logic sa_n_o = 1'b1,
	output logic sb_n_o = 1'b1
);
	logic rd = 1'b0;
	task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] id = 4'h0);
		int n;
		n = 0;
		if (mux_i) begin
			ale_o <= 1'b1;
			ad_o <= {id, a};
			@(posedge clock_i);
			ale_o <= 1'b0;
			@(posedge clock_i);
		end
		rd <= !wr;
		addr_o <= a;
		ad_o <= wr ? d : ~ad_o;
		cs_n_o <= 1'b0;
		sa_n_o <= style_i ? 1'b0 : wr;
		sb_n_o <= !wr;
		do begin
			@(posedge clock_i);
			n++;
		end while (!(fast_i ? ack_i : (wr ? n > 5 : !oe_n_i)) && n < 40);
		if (n == 40) begin
			quad_line_if_host_port_tb.n_errors++;
			quad_line_if_host_port_tb.summarize;
		end else begin
			cs_n_o <= 1'b1;
			sa_n_o <= 1'b1;
			sb_n_o <= 1'b1;
			ad_o <= ~ad_o;
			addr_o <= ~addr_o;
			repeat (4) @(posedge clock_i);
		end
	endtask
endmodule

// ===== test/quad_line_if_host_port_tb.sv
// Self-checking bench for the host port.
// Assumes host_model drives the bus pins.
`timescale 1ns/1ps
module quad_line_if_host_port_tb;
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic oe_q = 1'b1;
	logic [5:0] s = 6'h00;
	logic [3:0] alarm_i = 4'h0;
	logic [7:0] d;
	logic [7:0] q[$];
	int n_errors = 0, n_tests = 0, seed = 64092;
	wire [7:0] ad_o, ad_i;
	wire [3:0] addr_i;
	wire ale_i, cs_n_i, strobe_a_n_i, strobe_b_n_i, ad_oe_n_o, wait_acknowledge_out_o;
	wire alarm_irq_o, processor_mode_o, ref_clock_16x_o, ref_clock_e1_o;
	wire [7:0] ctrl_o;
	always #5 clock_i = ~clock_i;
	quad_line_if_host_port quad_line_if_host_port_i (.clock_i, .reset_i, .chip_mode_select_i(s[5]),
		.bus_multiplex_select_i(s[4]), .control_style_select_i(s[3]), .ref_clock_rate_select_i(s[2]),
		.ref_clock_standard_select_i(s[1]), .fast_host_i(s[0]), .addr_i, .ad_i, .ale_i, .cs_n_i,
		.strobe_a_n_i, .strobe_b_n_i, .alarm_i, .ad_o, .ad_oe_n_o, .wait_acknowledge_out_o, .alarm_irq_o,
		.processor_mode_o, .ref_clock_16x_o, .ref_clock_e1_o, .ctrl_o);
	host_model host_model_i (.clock_i, .mux_i(s[4]), .style_i(s[3]), .fast_i(s[0]), .oe_n_i(ad_oe_n_o),
		.ack_i(wait_acknowledge_out_o), .addr_o(addr_i), .ad_o(ad_i), .ale_o(ale_i), .cs_n_o(cs_n_i),
		.sa_n_o(strobe_a_n_i), .sb_n_o(strobe_b_n_i));
	task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rst(input logic [5:0] v);
		s <= v;
		reset_i <= 1'b1;
		repeat (8) @(posedge clock_i);
		reset_i <= 1'b0;
		repeat (5) @(posedge clock_i);
		cmp("mode", {7'h00, v[5]}, {7'h00, processor_mode_o});
		cmp("clk16", {7'h00, !v[2]}, {7'h00, ref_clock_16x_o});
		cmp("clk e1", {7'h00, v[2] & v[1]}, {7'h00, ref_clock_e1_o});
	endtask
	task automatic summarize;
		if (n_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Watcher: each fresh read drive is checked against the oldest note
	always @(posedge clock_i) begin
		oe_q <= ad_oe_n_o;
		if (oe_q && !ad_oe_n_o && host_model_i.rd) begin
			if (q.size() == 0)
				cmp("queued reads", 8'h01, 8'h00);
			else
				cmp("read data", q.pop_front(), ad_o);
		end
	end
	initial begin
		for (int i = 8; i >= 0; i--) begin
			rst({i != 8, i[2:1], 2'($random(seed)), i[0]});
			d = $random(seed);
			host_model_i.acc(1'b1, 4'h4, d);
			cmp("ctrl", (i < 8) ? d : 8'h00, ctrl_o);
			if (i < 8) begin
				q.push_back(d);
				host_model_i.acc(1'b0, 4'h4, 8'h00);
			end
			if (i[2] && !i[0]) begin
				host_model_i.acc(1'b1, 4'h4, ~d, 4'h5);
				cmp("ctrl other id", d, ctrl_o);
			end
		end
		d = 8'h01 << ($random(seed) & 3);
		alarm_i <= d[3:0];
		repeat (10) @(posedge clock_i);
		cmp("irq", 8'h01, {7'h00, alarm_irq_o});
		q.push_back(d);
		host_model_i.acc(1'b0, 4'h0, 8'h00);
		cmp("irq", 8'h00, {7'h00, alarm_irq_o});
		host_model_i.acc(1'b1, 4'h2, 8'h0f);
		alarm_i <= 4'h0;
		@(posedge clock_i);
		alarm_i <= 4'hf;
		repeat (10) @(posedge clock_i);
		cmp("irq", 8'h00, {7'h00, alarm_irq_o});
		summarize;
	end
endmodule
